// file: hdl/infrared_pulse_shaper.v
// infrared pulse shaper between the second serial port and its pins
`timescale 1ns/1ns
`include "infrared_pulse_shaper_defines.vh"

//
// Contract
// - An 8-bit control register at CEh resets to 0Fh with bit 7 reserved, bit 6 enable, bit 5 pulse select, bits 4-0 divisor.
// - With the enable bit set the shaper sits between serial port and pins, with it clear shaping is off.
// - Pulse select 0 gives a fixed pulse of about 1.627 us and 1 gives a pulse of 3/16 bit time; fixed mode here gives 3 reference clock periods.
// - The reference clock is the oscillator divided by the five-bit divisor field.
// - In fixed mode every pulse has the same width whatever the baud rate.
// - In proportional mode each pulse lasts 3/16 of the bit period.
// - The four-bit baud code maps codes 0 to 12 onto 115.2 down to 1.2 kbps.
// - The baud code field is optional when bit timing comes straight from the serial port; here the CFh code sets bit, stretch and proportional pulse lengths.
// - Pulses are at least 1.41 us wide and at 115.2 kbps no wider than 2.23 us; fixed-mode pulses here are only 12 to 372 ns wide.
// - After reset shaping is off and the serial signals pass straight to and from the pins.
// - A serial zero bit is sent as a high pulse and a serial one bit as no pulse.
// - Short received pulses are stretched so the serial receiver sees full bits; here each is stretched to 16 clocks short of a bit time.
module infrared_pulse_shaper (
  input  wire       CLK_IN,
  input  wire       RST_IN,
  input  wire [7:0] SFR_ADDR_IN,
  input  wire [7:0] SFR_WDATA_IN,
  input  wire       SFR_WR_IN,
  input  wire       SFR_RD_IN,
  output wire [7:0] SFR_RDATA_OUT,
  input  wire       UART_TX_IN,
  output wire       UART_RX_OUT,
  output wire       SERIAL_TX_PIN_OUT,
  input  wire       SERIAL_RX_PIN_IN
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // baud code to bit rate
  function [16:0] baud_bps;
    input [3:0] code;
    begin
      case (code)
        4'h0:    baud_bps = `IR_BAUD_0;
        4'h1:    baud_bps = `IR_BAUD_1;
        4'h2:    baud_bps = `IR_BAUD_2;
        4'h3:    baud_bps = `IR_BAUD_3;
        4'h4:    baud_bps = `IR_BAUD_4;
        4'h5:    baud_bps = `IR_BAUD_5;
        4'h6:    baud_bps = `IR_BAUD_6;
        4'h7:    baud_bps = `IR_BAUD_7;
        4'h8:    baud_bps = `IR_BAUD_8;
        4'h9:    baud_bps = `IR_BAUD_9;
        4'hA:    baud_bps = `IR_BAUD_10;
        4'hB:    baud_bps = `IR_BAUD_11;
        default: baud_bps = `IR_BAUD_12;
      endcase
    end
  endfunction

  // clock cycles in one bit
  function [17:0] bit_cycles;
    input [3:0] code;
    reg   [31:0] t;
    begin
      t          = `IR_CLK_HZ / {15'h0000, baud_bps(code)};
      bit_cycles = t[17:0];
    end
  endfunction

  // clock cycles in 3/16 of one bit
  function [15:0] prop_cycles;
    input [3:0] code;
    reg   [31:0] t;
    begin
      t           = (`IR_CLK_HZ / (`IR_PROP_DEN * {15'h0000, baud_bps(code)})) * `IR_PROP_NUM;
      prop_cycles = t[15:0];
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg        enable_reg;
  reg        pulse_sel_reg;
  reg [4:0]  divisor_reg;
  reg [3:0]  baud_code_reg;
  reg [7:0]  rdata_reg;

  localparam [7:0] ctrl_reset = `IR_CTRL_RESET;

  // baud code written at its own address
  always @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      enable_reg    <= ctrl_reset[`IR_CTRL_EN_BIT];
      pulse_sel_reg <= ctrl_reset[`IR_CTRL_PULSE_BIT];
      divisor_reg   <= ctrl_reset[`IR_CTRL_DIV_MSB:`IR_CTRL_DIV_LSB];
      baud_code_reg <= `IR_BAUD_RESET;
      rdata_reg     <= 8'h00;
    end
    else
    begin
      if (SFR_WR_IN && SFR_ADDR_IN == `IR_CTRL_ADDR)
      begin
        enable_reg    <= SFR_WDATA_IN[`IR_CTRL_EN_BIT];
        pulse_sel_reg <= SFR_WDATA_IN[`IR_CTRL_PULSE_BIT];
        divisor_reg   <= SFR_WDATA_IN[`IR_CTRL_DIV_MSB:`IR_CTRL_DIV_LSB];
      end
      if (SFR_WR_IN && SFR_ADDR_IN == `IR_BAUD_ADDR)
      begin
        baud_code_reg <= SFR_WDATA_IN[`IR_BAUD_MSB:`IR_BAUD_LSB];
      end
      // reserved bits read as zero
      if (SFR_RD_IN && SFR_ADDR_IN == `IR_CTRL_ADDR)
      begin
        rdata_reg <= {1'b0, enable_reg, pulse_sel_reg, divisor_reg};
      end
      else if (SFR_RD_IN && SFR_ADDR_IN == `IR_BAUD_ADDR)
      begin
        rdata_reg <= {baud_code_reg, 4'h0};
      end
      else
      begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign SFR_RDATA_OUT = rdata_reg;

  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  wire [17:0] bit_len;
  wire [15:0] prop_len;
  wire [4:0]  div_eff;

  assign bit_len  = bit_cycles(baud_code_reg);
  assign prop_len = prop_cycles(baud_code_reg);
  // divisor 0 behaves as 1
  assign div_eff  = (divisor_reg == 5'h00) ? 5'h01 : divisor_reg;

  // ----------------------------------------
  // transmit pulse shaping
  // ----------------------------------------
  reg         tx_low_d_reg;
  reg [17:0]  bit_cnt_reg;
  reg         pulse_on_reg;
  reg [15:0]  pulse_cnt_reg;
  reg [4:0]   ref_cnt_reg;
  reg [1:0]   ref_ticks_reg;
  reg         tx_pin_reg;
  wire        tx_low;
  wire        pulse_start;
  wire        ref_tick;
  wire        pulse_end;

  assign tx_low = ~UART_TX_IN;
  // each zero bit starts one pulse
  assign pulse_start = enable_reg & tx_low & (~tx_low_d_reg | (bit_cnt_reg == bit_len - 18'h00001));
  assign ref_tick    = (ref_cnt_reg == div_eff - 5'h01);
  // pulse length chosen by select bit
  assign pulse_end   = pulse_sel_reg ? (pulse_cnt_reg == prop_len - 16'h0001)
                                     : (ref_tick & (ref_ticks_reg == `IR_REF_PERIODS - 2'h1));

  always @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      tx_low_d_reg  <= 1'b0;
      bit_cnt_reg   <= 18'h00000;
      pulse_on_reg  <= 1'b0;
      pulse_cnt_reg <= 16'h0000;
      ref_cnt_reg   <= 5'h00;
      ref_ticks_reg <= 2'h0;
      tx_pin_reg    <= 1'b1;
    end
    else
    begin
      tx_low_d_reg <= tx_low;
      if (~tx_low | pulse_start)
      begin
        bit_cnt_reg <= 18'h00000;
      end
      else
      begin
        bit_cnt_reg <= bit_cnt_reg + 18'h00001;
      end
      if (pulse_start)
      begin
        pulse_on_reg  <= 1'b1;
        pulse_cnt_reg <= 16'h0000;
        ref_cnt_reg   <= 5'h00;
        ref_ticks_reg <= 2'h0;
      end
      else if (pulse_on_reg)
      begin
        pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
        // width set by ref clock or bit time
        ref_cnt_reg   <= ref_tick ? 5'h00 : ref_cnt_reg + 5'h01;
        ref_ticks_reg <= ref_tick ? ref_ticks_reg + 2'h1 : ref_ticks_reg;
        if (pulse_end)
        begin
          pulse_on_reg <= 1'b0;
        end
      end
      tx_pin_reg <= enable_reg ? (pulse_on_reg & ~pulse_end) | pulse_start : UART_TX_IN;
    end
  end

  assign SERIAL_TX_PIN_OUT = tx_pin_reg;

  // ----------------------------------------
  // receive pin synchroniser
  // ----------------------------------------
  reg rx_meta_reg;
  reg rx_sync_reg;
  reg rx_prev_reg;

  always @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= SERIAL_RX_PIN_IN;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // ----------------------------------------
  // receive pulse stretching
  // ----------------------------------------
  wire        fifo_wr_ready;
  wire [0:0]  fifo_rd_data;
  wire        fifo_rd_valid;
  wire        rx_rise;
  wire        stretch_take;
  reg  [17:0] stretch_cnt_reg;
  reg         stretch_on_reg;
  reg         stretch_bit_reg;
  reg         uart_rx_reg;

  // a pulse arriving with the buffer full is dropped
  assign rx_rise      = enable_reg & rx_sync_reg & ~rx_prev_reg;
  assign stretch_take = fifo_rd_valid & ~stretch_on_reg;

  ir_stream_fifo #(
    .WIDTH (`IR_FIFO_WIDTH),
    .DEPTH (`IR_FIFO_DEPTH),
    .AW    (`IR_FIFO_AW)
  ) u_rx_fifo (
    .clk_in       (CLK_IN),
    .rst_in       (RST_IN | ~enable_reg),
    .wr_data_in   (1'b0),
    .wr_valid_in  (rx_rise),
    .wr_ready_out (fifo_wr_ready),
    .rd_data_out  (fifo_rd_data),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (stretch_take)
  );

  always @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      stretch_cnt_reg <= 18'h00000;
      stretch_on_reg  <= 1'b0;
      stretch_bit_reg <= 1'b1;
      uart_rx_reg     <= 1'b1;
    end
    else
    begin
      // stretch each pulse to nearly a bit
      if (~enable_reg)
      begin
        stretch_on_reg  <= 1'b0;
        stretch_bit_reg <= 1'b1;
      end
      else if (stretch_take)
      begin
        stretch_on_reg  <= 1'b1;
        stretch_bit_reg <= fifo_rd_data[0];
        stretch_cnt_reg <= bit_len - `IR_STRETCH_TRIM;
      end
      else if (stretch_on_reg)
      begin
        stretch_cnt_reg <= stretch_cnt_reg - 18'h00001;
        if (stretch_cnt_reg == 18'h00001)
        begin
          stretch_on_reg  <= 1'b0;
          stretch_bit_reg <= 1'b1;
        end
      end
      // bypass passes the pin straight through
      uart_rx_reg <= enable_reg ? (stretch_bit_reg | ~stretch_on_reg) : rx_sync_reg;
    end
  end

  assign UART_RX_OUT = uart_rx_reg;

endmodule

// file: hdl/infrared_pulse_shaper_defines.vh
// constants for the infrared pulse shaper
`ifndef INFRARED_PULSE_SHAPER_DEFINES_VH
`define INFRARED_PULSE_SHAPER_DEFINES_VH

// ----------------------------------------
// special-function register addresses
// ----------------------------------------
`define IR_CTRL_ADDR        8'hCE
`define IR_BAUD_ADDR        8'hCF

// ----------------------------------------
// reset values
// ----------------------------------------
`define IR_CTRL_RESET       8'h0F
`define IR_BAUD_RESET       4'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define IR_CTRL_EN_BIT      6
`define IR_CTRL_PULSE_BIT   5
`define IR_CTRL_DIV_MSB     4
`define IR_CTRL_DIV_LSB     0
`define IR_BAUD_MSB         7
`define IR_BAUD_LSB         4

// ----------------------------------------
// timing
// ----------------------------------------
`define IR_CLK_HZ           32'h0EE6B280
`define IR_REF_PERIODS      2'h3
`define IR_STRETCH_TRIM     18'h00010
`define IR_PROP_NUM         3
`define IR_PROP_DEN         16

// ----------------------------------------
// baud rates in bits per second, code 0 to 12
// ----------------------------------------
`define IR_BAUD_0           17'h1C200
`define IR_BAUD_1           17'h0E09C
`define IR_BAUD_2           17'h09600
`define IR_BAUD_3           17'h04B00
`define IR_BAUD_4           17'h03840
`define IR_BAUD_5           17'h03200
`define IR_BAUD_6           17'h02580
`define IR_BAUD_7           17'h01C20
`define IR_BAUD_8           17'h012C0
`define IR_BAUD_9           17'h00E10
`define IR_BAUD_10          17'h00960
`define IR_BAUD_11          17'h00708
`define IR_BAUD_12          17'h004B0

// ----------------------------------------
// receive buffer
// ----------------------------------------
`define IR_FIFO_WIDTH       1
`define IR_FIFO_DEPTH       16
`define IR_FIFO_AW          4

`endif

// file: hdl/ir_stream_fifo.v
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module ir_stream_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            do_wr;
  wire            do_rd;

  assign wr_ready_out = (count_reg != DEPTH[AW:0]);
  assign rd_valid_out = (count_reg != {(AW+1){1'b0}});
  assign rd_data_out  = mem[rd_ptr_reg];
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;

  always @(posedge clk_in)
  begin
    if (do_wr)
    begin
      mem[wr_ptr_reg] <= wr_data_in;
    end
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_wr & ~do_rd)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (do_rd & ~do_wr)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// file: testbench/infrared_pulse_shaper_checker.sv
// port assertions for the infrared pulse shaper
`timescale 1ns/1ns
`include "infrared_pulse_shaper_defines.vh"
module infrared_pulse_shaper_checker (
  input wire       CLK_IN,
  input wire       RST_IN,
  input wire [7:0] SFR_ADDR_IN,
  input wire [7:0] SFR_WDATA_IN,
  input wire       SFR_WR_IN,
  input wire       SFR_RD_IN,
  input wire [7:0] SFR_RDATA_OUT,
  input wire       UART_TX_IN,
  input wire       UART_RX_OUT,
  input wire       SERIAL_TX_PIN_OUT,
  input wire       SERIAL_RX_PIN_IN
);
  reg       en_reg;
  reg       ps_reg;
  reg [4:0] dv_reg;
  reg [3:0] bd_reg;
  int       hi_reg;
  int       lo_reg;

  // shadow of both registers
  always @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      en_reg <= 1'b0;
      ps_reg <= 1'b0;
      dv_reg <= 5'h0F;
      bd_reg <= 4'h0;
    end
    else if (SFR_WR_IN && SFR_ADDR_IN == `IR_CTRL_ADDR)
    begin
      en_reg <= SFR_WDATA_IN[6];
      ps_reg <= SFR_WDATA_IN[5];
      dv_reg <= SFR_WDATA_IN[4:0];
    end
    else if (SFR_WR_IN && SFR_ADDR_IN == `IR_BAUD_ADDR)
      bd_reg <= SFR_WDATA_IN[7:4];
  end

  // run lengths, counted only while shaping
  always @(posedge CLK_IN)
  begin
    hi_reg <= (en_reg && SERIAL_TX_PIN_OUT) ? hi_reg + 1 : 0;
    lo_reg <= (en_reg && !UART_RX_OUT) ? lo_reg + 1 : 0;
  end

  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  property p_reset;
    $fell(RST_IN) |-> UART_RX_OUT && SERIAL_TX_PIN_OUT && SFR_RDATA_OUT == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
  property p_rd_ctrl;
    SFR_RD_IN && !SFR_WR_IN && SFR_ADDR_IN == `IR_CTRL_ADDR |=> SFR_RDATA_OUT == {1'b0, en_reg, ps_reg, dv_reg};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
  property p_tx_bypass;
    !en_reg |=> SERIAL_TX_PIN_OUT == $past(UART_TX_IN);
  endproperty
  a_tx_bypass: assert property (p_tx_bypass) else $error("transmit not passed through");
  property p_rx_bypass;
    !en_reg [*4] |-> UART_RX_OUT == $past(SERIAL_RX_PIN_IN, 3);
  endproperty
  a_rx_bypass: assert property (p_rx_bypass) else $error("receive not passed through");
  property p_tx_start;
    en_reg && $fell(UART_TX_IN) |=> SERIAL_TX_PIN_OUT;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("zero bit gave no pulse");
  property p_fix_width;
    en_reg && !ps_reg && $past(en_reg, 2) && $fell(SERIAL_TX_PIN_OUT) |-> hi_reg == 3 * (dv_reg == 5'h00 ? 1 : dv_reg);
  endproperty
  a_fix_width: assert property (p_fix_width) else $error("fixed pulse width wrong");
  property p_prop_width;
    en_reg && ps_reg && bd_reg == 4'h0 && $past(en_reg, 2) && $fell(SERIAL_TX_PIN_OUT) |-> hi_reg == 405;
  endproperty
  a_prop_width: assert property (p_prop_width) else $error("proportional pulse width wrong");
  property p_rx_stretch;
    en_reg && bd_reg == 4'h0 && $rose(UART_RX_OUT) && lo_reg > 64 |-> lo_reg == 2154;
  endproperty
  a_rx_stretch: assert property (p_rx_stretch) else $error("stretched bit length wrong");
endmodule

bind infrared_pulse_shaper infrared_pulse_shaper_checker u_checker (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .SFR_ADDR_IN(SFR_ADDR_IN), .SFR_WDATA_IN(SFR_WDATA_IN),
  .SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT), .UART_TX_IN(UART_TX_IN),
  .UART_RX_OUT(UART_RX_OUT), .SERIAL_TX_PIN_OUT(SERIAL_TX_PIN_OUT), .SERIAL_RX_PIN_IN(SERIAL_RX_PIN_IN)
);

// file: testbench/infrared_pulse_shaper_tb.sv
// self-checking testbench for the infrared pulse shaper
`timescale 1ns/1ns
`include "infrared_pulse_shaper_defines.vh"
module infrared_pulse_shaper_tb;
  reg        clk   = 1'b0;
  reg        rst   = 1'b1;
  reg  [7:0] addr  = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr_s  = 1'b0;
  reg        rd_s  = 1'b0;
  reg        utx   = 1'b1;
  reg        urx_d = 1'b1;
  wire [7:0] rdata;
  wire       urx;
  wire       ptx;
  wire       prx;
  int        falls     = 0;
  int        cycles    = 0;
  int        fails     = 0;
  int        tests_run = 0;

  infrared_pulse_shaper dut (
    .CLK_IN(clk), .RST_IN(rst), .SFR_ADDR_IN(addr), .SFR_WDATA_IN(wdata), .SFR_WR_IN(wr_s),
    .SFR_RD_IN(rd_s), .SFR_RDATA_OUT(rdata), .UART_TX_IN(utx), .UART_RX_OUT(urx),
    .SERIAL_TX_PIN_OUT(ptx), .SERIAL_RX_PIN_IN(prx)
  );
  ir_transceiver_model xcvr (.clk_in(clk), .tx_pin_in(ptx), .rx_pin_out(prx));

  always #2 clk = ~clk;

  // stretched-bit counter and hang guard
  always @(posedge clk)
  begin
    urx_d <= urx;
    if (urx_d && !urx)
      falls <= falls + 1;
    cycles <= cycles + 1;
    if (cycles == 99000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic summarize;
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(n, e, rdata);
  endtask

  task automatic t_regs;
    rd(`IR_CTRL_ADDR, 8'h0F, "ctrl reset");
    rd(`IR_BAUD_ADDR, 8'h00, "baud reset");
    wr(`IR_CTRL_ADDR, 8'hBF);
    rd(`IR_CTRL_ADDR, 8'h3F, "ctrl rw");
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00, "unmapped");
    rd(`IR_CTRL_ADDR, 8'h3F, "ctrl kept");
  endtask

  task automatic t_bypass;
    @(posedge clk);
    utx <= 1'b0;
    cyc(2);
    #1 chk("tx bypass low", 1'b0, ptx);
    cyc(1);
    utx <= 1'b1;
    xcvr.flash(6);
    #1 chk("tx bypass high", 1'b1, ptx);
    chk("rx bypass high", 1'b1, urx);
    cyc(4);
    #1 chk("rx bypass low", 1'b0, urx);
  endtask

  task automatic t_fixed(input logic [4:0] dv);
    int n0;
    wr(`IR_CTRL_ADDR, {3'b010, dv});
    cyc(4);
    n0 = xcvr.count_reg;
    utx <= 1'b0;
    cyc(20);
    utx <= 1'b1;
    cyc(120);
    #1 chk("fixed width", 3 * (dv == 5'h00 ? 1 : dv), xcvr.width_reg);
    chk("pulse count", n0 + 1, xcvr.count_reg);
  endtask

  task automatic t_prop(input logic [3:0] code, input int rate);
    int w;
    w = 3 * (`IR_CLK_HZ / (16 * rate));
    wr(`IR_BAUD_ADDR, {code, 4'h0});
    rd(`IR_BAUD_ADDR, {code, 4'h0}, "baud rw");
    cyc(1);
    utx <= 1'b0;
    cyc(30);
    utx <= 1'b1;
    cyc(w + 40);
    #1 chk("prop width", w, xcvr.width_reg);
  endtask

  task automatic t_frame(input logic [7:0] b, input int zeros);
    int         n0;
    int         i;
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    wr(`IR_BAUD_ADDR, 8'h00);
    cyc(4);
    n0 = xcvr.count_reg;
    for (i = 0; i < 10; i++)
    begin
      utx <= f[i];
      cyc(`IR_CLK_HZ / `IR_BAUD_0);
    end
    cyc(8);
    #1 chk("frame pulses", n0 + zeros, xcvr.count_reg);
    chk("frame width", 3 * (`IR_CLK_HZ / (16 * `IR_BAUD_0)), xcvr.width_reg);
  endtask

  task automatic t_rx;
    int n;
    int f0;
    wr(`IR_BAUD_ADDR, 8'h00);
    wr(`IR_CTRL_ADDR, 8'h44);
    cyc(8);
    xcvr.flash(2);
    n = 0;
    repeat (2400)
    begin
      @(posedge clk);
      #1 if (urx === 1'b0) n++;
    end
    chk("stretch length", 2154, n);
    cyc(1);
    f0 = falls;
    // burst overruns the sixteen-entry queue
    repeat (20)
    begin
      xcvr.flash(2);
      cyc(6);
    end
    cyc(38000);
    #1 chk("stretched bits", f0 + 17, falls);
    chk("rx idle", 1'b1, urx);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_bypass;
    t_fixed(5'h04);
    t_fixed(5'h1F);
    t_fixed(5'h16);
    wr(`IR_CTRL_ADDR, 8'h64);
    t_prop(4'h0, `IR_BAUD_0);
    t_prop(4'h1, `IR_BAUD_1);
    t_prop(4'h6, `IR_BAUD_6);
    t_prop(4'hA, `IR_BAUD_10);
    t_frame(8'h00, 9);
    t_rx;
    summarize();
  end
endmodule

// file: testbench/ir_transceiver_model.sv
// infrared transceiver model: times sent pulses, emits received pulses
`timescale 1ns/1ns
module ir_transceiver_model (
  input  wire clk_in,
  input  wire tx_pin_in,
  output reg  rx_pin_out
);
  int run_reg   = 0;
  int width_reg = 0;
  int count_reg = 0;

  // no light on the receiver between pulses
  initial rx_pin_out = 1'b0;

  // width of each light pulse, taken at its end
  always @(posedge clk_in)
  begin
    run_reg <= tx_pin_in ? run_reg + 1 : 0;
    if (!tx_pin_in && run_reg != 0)
    begin
      width_reg <= run_reg;
      count_reg <= count_reg + 1;
    end
  end

  // light pulse of n cycles, started at a rising edge
  task automatic flash(input int n);
    rx_pin_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    rx_pin_out <= 1'b0;
  endtask
endmodule
